// ### hdl/ccr_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - Load priority 0, low rail: charging inhibited
// RULE2 - Load priority 1, low rail: reduce current
// RULE3 - Termination method bits 1:0, reset 00
// RULE4 - Method 00: timeout is count times 2min
// RULE5 - Method low bit 1: count times 10min
// RULE6 - Good threshold bits 4:3, below means recovery
// RULE7 - Recovery current bits 7:5, reset 011
// RULE8 - Charger off stops charging, rail 3.6V
// RULE9 - Recharge off: one cycle until reset
// RULE10 - Disable bits active high, reset zero
module ccr_top
  import ccr_pkg::*;
#(
  parameter int MINUTE_CYCLES = int'(CCR_MINUTE_CYCLES)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic addr_hit_out,
  input wire logic sys_low_pin_in,
  input wire logic batt_low_pin_in,
  input wire logic cv_mode_pin_in,
  input wire logic batt_full_pin_in,
  output logic charge_en_out,
  output logic current_reduce_out,
  output logic recovery_mode_out,
  output logic [2:0] recovery_current_sel_out,
  output logic [1:0] battery_good_threshold_out,
  output logic termination_current_sel_out,
  output logic lockout_level_sel_out,
  output logic thermistor_guard_off_out,
  output logic const_voltage_loop_off_out,
  output logic const_current_loop_off_out,
  output logic rail_nominal_out,
  output logic terminated_out
);
  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (MINUTE_CYCLES < 1) begin : g_bad_minute
    $error("MINUTE_CYCLES must be positive");
  end
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins are asynchronous, so only the second stage feeds logic
  logic [3:0] meta_ff, sync_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end else begin
      meta_ff <= {batt_full_pin_in, cv_mode_pin_in, batt_low_pin_in, sys_low_pin_in};
      sync_ff <= meta_ff;
    end
  end
  logic sys_low, batt_low, cv_mode, batt_full;
  assign {batt_full, cv_mode, batt_low, sys_low} = sync_ff;
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] term_ctrl_ff, nxt_term_ctrl;
  logic [7:0] app_set_ff, nxt_app_set;
  logic [7:0] special_ff, nxt_special;
  // Reserved bits are stored so software reads back what it wrote
  function automatic logic hit(input logic [7:0] a);
    hit = (a == CCR_TERM_CTRL_OFS) || (a == CCR_APP_SET_OFS) || (a == CCR_SPECIAL_OFS);
  endfunction : hit
  always_comb begin
    nxt_term_ctrl = term_ctrl_ff;
    nxt_app_set = app_set_ff;
    nxt_special = special_ff;
    if (wr_en_in) begin
      if (addr_in == CCR_TERM_CTRL_OFS) nxt_term_ctrl = wdata_in;
      if (addr_in == CCR_APP_SET_OFS) nxt_app_set = wdata_in;
      if (addr_in == CCR_SPECIAL_OFS) nxt_special = wdata_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      term_ctrl_ff <= CCR_TERM_CTRL_RST; // see RULE3
      app_set_ff <= CCR_APP_SET_RST; // see RULE6
      special_ff <= CCR_SPECIAL_RST; // see RULE10
    end else begin
      term_ctrl_ff <= nxt_term_ctrl;
      app_set_ff <= nxt_app_set;
      special_ff <= nxt_special;
    end
  end
  always_comb begin
    addr_hit_out = hit(addr_in);
    unique case (addr_in)
      CCR_TERM_CTRL_OFS: rdata_out = term_ctrl_ff;
      CCR_APP_SET_OFS: rdata_out = app_set_ff;
      CCR_SPECIAL_OFS: rdata_out = special_ff;
      default: rdata_out = 8'h00;
    endcase
  end
  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic [1:0] termination_method;
  logic [4:0] term_count;
  logic charger_off, recharge_off, load_priority_select;
  assign termination_method = term_ctrl_ff[CCR_METHOD_LSB +: 2];
  assign term_count = term_ctrl_ff[CCR_TIMER_LSB +: 5];
  assign charger_off = special_ff[CCR_CHG_OFF_BIT];
  assign recharge_off = special_ff[CCR_RCH_OFF_BIT];
  assign load_priority_select = special_ff[CCR_PRIO_BIT];
  // ---------------------------------------------------------------
  // Charge cycle state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CCR_IDLE, CCR_CHARGING, CCR_DONE} ccr_state_t;
  ccr_state_t state_ff, nxt_state;
  logic once_ff, nxt_once;
  logic expired;
  always_comb begin
    nxt_state = state_ff;
    nxt_once = once_ff;
    unique case (state_ff)
      CCR_IDLE: begin
        // A finished cycle blocks restart only while recharge is disabled
        if (!charger_off && !(recharge_off && once_ff)) nxt_state = CCR_CHARGING; // see RULE9
      end
      CCR_CHARGING: begin
        if (charger_off) begin
          nxt_state = CCR_IDLE; // see RULE8
        end else if (expired) begin
          nxt_state = CCR_DONE;
          nxt_once = 1'b1;
        end
      end
      CCR_DONE: begin
        if (charger_off) nxt_state = CCR_IDLE;
        else if (!batt_full && !recharge_off) nxt_state = CCR_CHARGING; // see RULE9
      end
      default: nxt_state = CCR_IDLE;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= CCR_IDLE;
      once_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      once_ff <= nxt_once;
    end
  end
  ccr_term_timer #(
    .MINUTE_CYCLES(MINUTE_CYCLES)
  ) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in((state_ff == CCR_CHARGING) && cv_mode),
    .method_in(termination_method),
    .count_in(term_count),
    .expired_out(expired)
  );
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    // Priority bit only matters while the rail is below instant-on
    charge_en_out = (state_ff == CCR_CHARGING) && !charger_off // see RULE8
                    && !(sys_low && !load_priority_select); // see RULE1
    current_reduce_out = charge_en_out && sys_low && load_priority_select; // see RULE2
    recovery_mode_out = charge_en_out && batt_low; // see RULE6
    recovery_current_sel_out = app_set_ff[CCR_RECOV_LSB +: 3]; // see RULE7
    battery_good_threshold_out = app_set_ff[CCR_GOOD_LSB +: 2];
    termination_current_sel_out = term_ctrl_ff[CCR_TERMINATION_CURRENT_SEL_BIT];
    lockout_level_sel_out = app_set_ff[CCR_LOCKOUT_BIT];
    thermistor_guard_off_out = special_ff[CCR_NTC_OFF_BIT]; // see RULE10
    const_voltage_loop_off_out = special_ff[CCR_CV_OFF_BIT];
    const_current_loop_off_out = special_ff[CCR_CC_OFF_BIT];
    rail_nominal_out = charger_off; // see RULE8
    terminated_out = (state_ff == CCR_DONE);
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_inhibit_low_rail: assert property (sys_low && !load_priority_select |-> !charge_en_out) // see RULE1
    else $error("charging while rail low with load priority");
  a_reduce_low_rail: assert property (charge_en_out && sys_low |-> current_reduce_out) // see RULE2
    else $error("no current reduction on low rail");
  a_method_write: assert property (wr_en_in && addr_in == CCR_TERM_CTRL_OFS // see RULE3
      |=> termination_method == $past(wdata_in[1:0]))
    else $error("termination method not written");
  a_timer_short: assert property ($rose(expired) && !termination_method[0] // see RULE4
      |-> u_timer.min_ff >= 10'(term_count * CCR_SHORT_STEP_MIN))
    else $error("short timeout early");
  a_timer_long: assert property ($rose(expired) && termination_method[0] // see RULE5
      |-> u_timer.min_ff >= 10'(term_count * CCR_LONG_STEP_MIN))
    else $error("long timeout early");
  a_recovery_on: assert property (charge_en_out && batt_low |-> recovery_mode_out) // see RULE6
    else $error("recovery not applied");
  a_recovery_cur: assert property (recovery_current_sel_out == app_set_ff[7:5]) // see RULE7
    else $error("recovery current mismatch");
  a_charger_off: assert property (charger_off |-> !charge_en_out && rail_nominal_out) // see RULE8
    else $error("charging while charger off");
  a_single_cycle: assert property (recharge_off && once_ff |=> state_ff != CCR_CHARGING // see RULE9
      || $past(state_ff) == CCR_CHARGING)
    else $error("recharge while disabled");
  a_disable_write: assert property (wr_en_in && addr_in == CCR_SPECIAL_OFS // see RULE10
      |=> charger_off == $past(wdata_in[0]))
    else $error("disable bit not written");
  a_reset_values: assert property ($fell(rst_in) |-> term_ctrl_ff == CCR_TERM_CTRL_RST // see RULE10
      && app_set_ff == CCR_APP_SET_RST && special_ff == CCR_SPECIAL_RST)
    else $error("register reset value wrong");
  a_done_hold: assert property (state_ff == CCR_DONE && recharge_off && !charger_off // see RULE9
      |=> state_ff == CCR_DONE)
    else $error("finished cycle restarted while recharge disabled");
  c_charging: cover property (charge_en_out);
  c_reduced: cover property (current_reduce_out);
  c_done: cover property (terminated_out);
  c_recovery: cover property (recovery_mode_out);
  c_no_restart: cover property (recharge_off && once_ff && state_ff == CCR_IDLE);
endmodule : ccr_top

// ### hdl/ccr_pkg.sv
package ccr_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CCR_TERM_CTRL_OFS = 8'h92;
  localparam logic [7:0] CCR_APP_SET_OFS = 8'h93;
  localparam logic [7:0] CCR_SPECIAL_OFS = 8'h94;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CCR_TERM_CTRL_RST = 8'h04;
  localparam logic [7:0] CCR_APP_SET_RST = 8'h78;
  localparam logic [7:0] CCR_SPECIAL_RST = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CCR_METHOD_LSB = 0;
  localparam int CCR_TIMER_LSB = 2;
  localparam int CCR_TERMINATION_CURRENT_SEL_BIT = 7;
  localparam int CCR_LOCKOUT_BIT = 0;
  localparam int CCR_GOOD_LSB = 3;
  localparam int CCR_RECOV_LSB = 5;
  localparam int CCR_CHG_OFF_BIT = 0;
  localparam int CCR_RCH_OFF_BIT = 1;
  localparam int CCR_NTC_OFF_BIT = 2;
  localparam int CCR_CV_OFF_BIT = 3;
  localparam int CCR_CC_OFF_BIT = 4;
  localparam int CCR_PRIO_BIT = 5;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CCR_CLK_HZ = 25_000_000;
  localparam int CCR_SHORT_STEP_MIN = 2;
  localparam int CCR_LONG_STEP_MIN = 10;
  localparam longint CCR_MINUTE_CYCLES = 60 * longint'(CCR_CLK_HZ);
endpackage : ccr_pkg

// ### hdl/ccr_term_timer.sv
`timescale 1ns/100ps
module ccr_term_timer
  import ccr_pkg::*;
#(
  parameter int MINUTE_CYCLES = int'(CCR_MINUTE_CYCLES)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [1:0] method_in,
  input wire logic [4:0] count_in,
  output logic expired_out
);
  if (MINUTE_CYCLES < 1) begin : g_bad_minute
    $error("MINUTE_CYCLES must be positive");
  end
  // ---------------------------------------------------------------
  // Minute tick divider
  // ---------------------------------------------------------------
  logic [31:0] div_ff, nxt_div;
  logic tick;
  logic [9:0] min_ff, nxt_min;
  logic [9:0] limit;
  logic exp_ff, nxt_exp;
  always_comb begin
    tick = run_in && (div_ff == 32'(MINUTE_CYCLES - 1));
    nxt_div = (!run_in || tick) ? 32'h0000_0000 : div_ff + 32'h0000_0001;
    // Method 00 steps 2 minutes, x1 steps 10; 10 has no rule so it runs 2 as well
    limit = method_in[0] ? 10'(count_in * CCR_LONG_STEP_MIN) // see RULE5
                         : 10'(count_in * CCR_SHORT_STEP_MIN); // see RULE4
    nxt_min = !run_in ? 10'h000 : (tick && !exp_ff) ? min_ff + 10'h001 : min_ff;
    nxt_exp = run_in && (exp_ff || (nxt_min >= limit)); // see RULE3
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_ff <= 32'h0000_0000;
      min_ff <= 10'h000;
      exp_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      min_ff <= nxt_min;
      exp_ff <= nxt_exp;
    end
  end
  assign expired_out = exp_ff;
endmodule : ccr_term_timer

// ### tb/tb_ccr_top.sv
`timescale 1ns/100ps
module tb_ccr_top;
  import ccr_pkg::*;
  // Short minute keeps every timeout test's timeout to 120 cycles or fewer
  localparam int MIN_CYC = 4;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_en_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic sys_low_pin_in = 1'b0, batt_low_pin_in = 1'b0, cv_mode_pin_in = 1'b0;
  logic batt_full_pin_in = 1'b0;
  logic [7:0] rdata_out;
  logic [2:0] rec_cur;
  logic [1:0] good_th;
  logic hit, chg_en, cur_red, recov, termination_current_sel, lockout, ntc_off, cv_off, cc_off, rail_nom, done;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int mdl[3];
  ccr_top #(.MINUTE_CYCLES(MIN_CYC)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .wr_en_in(wr_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .addr_hit_out(hit), .sys_low_pin_in(sys_low_pin_in), .batt_low_pin_in(batt_low_pin_in),
    .cv_mode_pin_in(cv_mode_pin_in), .batt_full_pin_in(batt_full_pin_in),
    .charge_en_out(chg_en), .current_reduce_out(cur_red), .recovery_mode_out(recov),
    .recovery_current_sel_out(rec_cur), .battery_good_threshold_out(good_th),
    .termination_current_sel_out(termination_current_sel), .lockout_level_sel_out(lockout),
    .thermistor_guard_off_out(ntc_off), .const_voltage_loop_off_out(cv_off),
    .const_current_loop_off_out(cc_off), .rail_nominal_out(rail_nom), .terminated_out(done));
  // ---------------------------------------------------------------
  // Clock, watchdog and verdict
  // ---------------------------------------------------------------
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // ---------------------------------------------------------------
  // Register access and model
  // ---------------------------------------------------------------
  task automatic do_reset;
    @(posedge clk_in);
    #1 rst_in = 1'b1;
    repeat (8) @(posedge clk_in);
    #1 rst_in = 1'b0;
    mdl[0] = {1'b0, 5'b0_0001, 2'b00};
    mdl[1] = {3'b011, 2'b11, 2'b00, 1'b0};
    mdl[2] = 0;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 wr_en_in = 1'b1;
    addr_in = a;
    wdata_in = d;
    @(posedge clk_in);
    #1 wr_en_in = 1'b0;
    if (a >= CCR_TERM_CTRL_OFS && a <= CCR_SPECIAL_OFS) mdl[a - CCR_TERM_CTRL_OFS] = d;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a);
    logic h;
    h = (a >= CCR_TERM_CTRL_OFS && a <= CCR_SPECIAL_OFS);
    @(posedge clk_in);
    #1 addr_in = a;
    #5;
    chk("rdata", h ? 8'(mdl[a - CCR_TERM_CTRL_OFS]) : 8'h00, rdata_out);
    chk("addr_hit", {7'b0, h}, {7'b0, hit});
  endtask : rd_chk
  task automatic chk_dec;
    logic [7:0] t, a, s;
    t = 8'(mdl[0]);
    a = 8'(mdl[1]);
    s = 8'(mdl[2]);
    chk("recovery_current", {5'b0, a[7:5]}, {5'b0, rec_cur});
    chk("good_threshold", {6'b0, a[4:3]}, {6'b0, good_th});
    chk("term_current", {7'b0, t[7]}, {7'b0, termination_current_sel});
    chk("lockout", {7'b0, a[0]}, {7'b0, lockout});
    chk("loop_guard_offs", {5'b0, s[4:2]}, {5'b0, cc_off, cv_off, ntc_off});
    chk("rail_nominal", {7'b0, s[0]}, {7'b0, rail_nom});
  endtask : chk_dec
  // Timeout measured from the cv edge; pin sync only adds delay, so early is a fault
  task automatic tmr(input logic [1:0] m, input int c);
    int t;
    int w;
    do_reset();
    batt_full_pin_in = 1'b1;
    wr(CCR_TERM_CTRL_OFS, {1'b0, c[4:0], m});
    t = c * (m[0] ? CCR_LONG_STEP_MIN : CCR_SHORT_STEP_MIN) * MIN_CYC;
    cv_mode_pin_in = 1'b1;
    repeat (t - 1) @(posedge clk_in);
    #1 chk("terminated_early", 8'h00, {7'b0, done});
    w = 0;
    while (done !== 1'b1 && w < 10) begin
      @(posedge clk_in);
      #1 w++;
    end
    chk("terminated", 8'h01, {7'b0, done});
    cv_mode_pin_in = 1'b0;
  endtask : tmr
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] a;
    void'($urandom(32'h9d9f_e192));
    do_reset();
    for (int i = 8'h91; i <= 8'h95; i++) rd_chk(8'(i));
    chk_dec();
    repeat (5) @(posedge clk_in);
    #1 chk("charge_default", 8'h01, {7'b0, chg_en});
    sys_low_pin_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #1 chk("charge_low_rail", 8'h00, {6'b0, cur_red, chg_en});
    wr(CCR_SPECIAL_OFS, 8'h20);
    repeat (3) @(posedge clk_in);
    #1 chk("reduce_low_rail", 8'h03, {6'b0, cur_red, chg_en});
    sys_low_pin_in = 1'b0;
    wr(CCR_SPECIAL_OFS, 8'h01);
    #1 chk("charger_off", 8'h02, {6'b0, rail_nom, chg_en});
    wr(CCR_SPECIAL_OFS, 8'h00);
    batt_low_pin_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #1 chk("recovery", 8'h01, {7'b0, recov});
    batt_low_pin_in = 1'b0;
    for (int i = 0; i < 24; i++) begin
      a = (i % 4 == 3) ? 8'($urandom % 256) : 8'(CCR_TERM_CTRL_OFS + i % 4);
      wr(a, 8'($urandom));
      rd_chk(a);
      rd_chk(CCR_SPECIAL_OFS);
      chk_dec();
    end
    tmr(2'b00, 3);
    tmr(2'b10, 2);
    tmr(2'b01, 2);
    tmr(2'b11, 1 + $urandom % 3);
    wr(CCR_SPECIAL_OFS, 8'h02);
    batt_full_pin_in = 1'b0;
    repeat (8) @(posedge clk_in);
    #1 chk("single_cycle", 8'h01, {7'b0, done});
    wr(CCR_SPECIAL_OFS, 8'h03);
    wr(CCR_SPECIAL_OFS, 8'h02);
    repeat (4) @(posedge clk_in);
    #1 chk("no_restart", 8'h00, {6'b0, done, chg_en});
    tmr(2'b00, 1 + $urandom % 4);
    batt_full_pin_in = 1'b0;
    repeat (8) @(posedge clk_in);
    #1 chk("recharge", 8'h00, {7'b0, done});
    end_sim();
  end
endmodule : tb_ccr_top
